// [cpu_status_pkg.sv]
/*
 * constants shared by the cpu status flag register: register offsets,
 * field positions inside each register, reset values and event bits.
 * assumes a plain word-addressed register port with 16-bit data.
 */
`default_nettype none

package cpu_status_pkg;

   // register port geometry
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;

   // register offsets on the register port
   localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_CORE_CTRL = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_INT_CTRL_ONE = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 3'h4;

   // status register field positions
   localparam int BIT_ACC_A_OVERFLOW = 15;
   localparam int BIT_ACC_B_OVERFLOW = 14;
   localparam int BIT_ACC_A_SAT = 13;
   localparam int BIT_ACC_B_SAT = 12;
   localparam int BIT_ANY_OVERFLOW = 11;
   localparam int BIT_ANY_SAT = 10;
   localparam int BIT_LOOP_ACTIVE = 9;
   localparam int BIT_HALF_CARRY = 8;
   localparam int BIT_PRIO_HI = 7;
   localparam int BIT_PRIO_LO = 5;
   localparam int BIT_REPEAT_ACTIVE = 4;
   localparam int BIT_NEGATIVE = 3;
   localparam int BIT_SIGNED_OVF = 2;
   localparam int BIT_ZERO = 1;
   localparam int BIT_CARRY = 0;

   // other registers
   localparam int BIT_PRIO_TOP = 3;       // in core control
   localparam int BIT_NEST_DISABLE = 15;  // in interrupt control one

   // carry positions in the alu carry vector
   localparam int CY_BYTE_HALF = 4;
   localparam int CY_BYTE_SIGN = 7;
   localparam int CY_BYTE_OUT = 8;
   localparam int CY_WORD_HALF = 8;
   localparam int CY_WORD_SIGN = 15;
   localparam int CY_WORD_OUT = 16;

   // event bits in event status and mask
   localparam int EVT_W = 4;
   localparam int EVT_SAT_A = 0;
   localparam int EVT_SAT_B = 1;
   localparam int EVT_OVF_A = 2;
   localparam int EVT_OVF_B = 3;

   // reset values
   localparam logic [DATA_W-1:0] RST_STATUS = 16'h0000;
   localparam logic [EVT_W-1:0] RST_EVT = 4'h0;
   localparam logic [2:0] RST_PRIO = 3'h0;

endpackage

`default_nettype wire

// [cpu_status_flag_register.sv]
/*
 * cpu status flag register: accumulator overflow and sticky saturation
 * flags, loop activity, alu flags and the cpu priority level, plus core
 * control, nesting control and a small event interrupt unit.
 * assumes the alu, dsp engine, loop hardware and interrupt controller run
 * on the same clock and drive their inputs straight from logic.
 */
// The implementer's own choices: the register offsets and the plain strobed port.
`default_nettype none


module cpu_status_flag_register
   import cpu_status_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [cpu_status_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [cpu_status_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [cpu_status_pkg::DATA_W-1:0] reg_rdata,
   // dsp engine accumulator status
   input wire logic acc_update,
   input wire logic acc_a_overflow_in,
   input wire logic acc_b_overflow_in,
   input wire logic acc_a_saturate,
   input wire logic acc_b_saturate,
   // loop hardware
   input wire logic do_loop_busy,
   input wire logic repeat_loop_busy,
   // alu result flags
   input wire logic alu_update,
   input wire logic alu_byte_op,
   input wire logic [16:0] alu_carries,
   input wire logic alu_negative,
   input wire logic alu_zero,
   input wire logic alu_zero_sticky,
   // interrupt controller priority load
   input wire logic prio_load,
   input wire logic [3:0] prio_load_value,
   // outputs
   output logic [cpu_status_pkg::DATA_W-1:0] cpu_status_flags,
   output logic [3:0] cpu_priority_level,
   output logic user_irq_block,
   output logic irq
);

   // synchronised reset copy
   logic rst_meta_reg;
   logic rst_sync_n;

   // status register state
   logic [1:0] acc_ovf_reg;
   logic [1:0] acc_sat_reg;
   logic loop_active_flag;
   logic repeat_active_flag;
   logic half_carry_flag;
   logic [2:0] cpu_priority_low;
   logic negative_flag;
   logic signed_overflow_flag;
   logic zero_flag;
   logic carry_flag;

   // other registers
   logic cpu_priority_top;
   logic nesting_disable;
   logic [EVT_W-1:0] evt_status_reg;
   logic [EVT_W-1:0] evt_mask_reg;

   // decoded strobes and derived values
   logic wr_status;
   logic wr_core;
   logic wr_intc;
   logic wr_evt;
   logic wr_mask;
   logic [1:0] acc_ovf_in;
   logic [1:0] acc_sat_in;
   logic [1:0] acc_ovf_rise;
   logic [EVT_W-1:0] evt_in;
   logic alu_half;
   logic alu_carry;
   logic alu_ovf;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] read_mux;

   // reset release through two flip-flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n <= rst_meta_reg;
      end
   end

   // address decode of write strobes
   assign wr_status = reg_wr && (reg_addr == OFS_STATUS);
   assign wr_core = reg_wr && (reg_addr == OFS_CORE_CTRL);
   assign wr_intc = reg_wr && (reg_addr == OFS_INT_CTRL_ONE);
   assign wr_evt = reg_wr && (reg_addr == OFS_EVT_STATUS);
   assign wr_mask = reg_wr && (reg_addr == OFS_EVT_MASK);

   // per accumulator inputs gathered as vectors, a in bit 0
   assign acc_ovf_in = {acc_b_overflow_in, acc_a_overflow_in};
   assign acc_sat_in = {acc_b_saturate, acc_a_saturate};

   // per accumulator overflow and sticky saturation flags
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_acc
         localparam int OVF_POS = (g == 0) ? BIT_ACC_A_OVERFLOW : BIT_ACC_B_OVERFLOW;
         localparam int SAT_POS = (g == 0) ? BIT_ACC_A_SAT : BIT_ACC_B_SAT;

         // overflow follows the engine, software write in between
         always_ff @(posedge clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               acc_ovf_reg[g] <= 1'b0;
            end else if (acc_update) begin
               acc_ovf_reg[g] <= acc_ovf_in[g];
            end else if (wr_status) begin
               acc_ovf_reg[g] <= reg_wdata[OVF_POS];
            end
         end

         // sticky saturation: the set wins over any write
         always_ff @(posedge clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               acc_sat_reg[g] <= 1'b0;
            end else if (acc_sat_in[g]) begin
               acc_sat_reg[g] <= 1'b1;
            end else if (wr_status) begin
               acc_sat_reg[g] <= reg_wdata[SAT_POS] & reg_wdata[BIT_ANY_SAT];
            end
         end

         // rising edge of overflow for the event unit
         assign acc_ovf_rise[g] = acc_update && acc_ovf_in[g] && !acc_ovf_reg[g];
      end
   endgenerate

   // loop activity mirrors the loop hardware, writes have no effect
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         loop_active_flag <= 1'b0;
         repeat_active_flag <= 1'b0;
      end else begin
         loop_active_flag <= do_loop_busy;
         repeat_active_flag <= repeat_loop_busy;
      end
   end

   // carry taps selected by operand size
   assign alu_half = alu_byte_op ? alu_carries[CY_BYTE_HALF] : alu_carries[CY_WORD_HALF];
   assign alu_carry = alu_byte_op ? alu_carries[CY_BYTE_OUT] : alu_carries[CY_WORD_OUT];
   // signed overflow: carry into sign differs from carry out of it
   assign alu_ovf = alu_byte_op ? (alu_carries[CY_BYTE_SIGN] ^ alu_carries[CY_BYTE_OUT])
                                : (alu_carries[CY_WORD_SIGN] ^ alu_carries[CY_WORD_OUT]);

   // alu flags: an alu result wins over a software write
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         half_carry_flag <= 1'b0;
         negative_flag <= 1'b0;
         signed_overflow_flag <= 1'b0;
         carry_flag <= 1'b0;
      end else if (alu_update) begin
         half_carry_flag <= alu_half;
         negative_flag <= alu_negative;
         signed_overflow_flag <= alu_ovf;
         carry_flag <= alu_carry;
      end else if (wr_status) begin
         half_carry_flag <= reg_wdata[BIT_HALF_CARRY];
         negative_flag <= reg_wdata[BIT_NEGATIVE];
         signed_overflow_flag <= reg_wdata[BIT_SIGNED_OVF];
         carry_flag <= reg_wdata[BIT_CARRY];
      end
   end

   // zero flag; sticky mode only ever clears it, for multi-word results
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         zero_flag <= 1'b0;
      end else if (alu_update) begin
         zero_flag <= alu_zero_sticky ? (zero_flag & alu_zero) : alu_zero;
      end else if (wr_status) begin
         zero_flag <= reg_wdata[BIT_ZERO];
      end
   end

   // low priority bits: controller load first, then unlocked writes
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cpu_priority_low <= RST_PRIO;
      end else if (prio_load) begin
         cpu_priority_low <= prio_load_value[2:0];
      end else if (wr_status && !nesting_disable) begin
         cpu_priority_low <= reg_wdata[BIT_PRIO_HI:BIT_PRIO_LO];
      end
   end

   // top priority bit lives in core control
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cpu_priority_top <= 1'b0;
      end else if (prio_load) begin
         cpu_priority_top <= prio_load_value[3];
      end else if (wr_core) begin
         cpu_priority_top <= reg_wdata[BIT_PRIO_TOP];
      end
   end

   // nesting disable in interrupt control one
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         nesting_disable <= 1'b0;
      end else if (wr_intc) begin
         nesting_disable <= reg_wdata[BIT_NEST_DISABLE];
      end
   end

   // events: saturation and new overflow of either accumulator
   always_comb begin
      evt_in = '0;
      evt_in[EVT_SAT_A] = acc_sat_in[0];
      evt_in[EVT_SAT_B] = acc_sat_in[1];
      evt_in[EVT_OVF_A] = acc_ovf_rise[0];
      evt_in[EVT_OVF_B] = acc_ovf_rise[1];
   end

   // event status: write one to clear, a new event wins
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         evt_status_reg <= RST_EVT;
      end else if (wr_evt) begin
         evt_status_reg <= (evt_status_reg & ~reg_wdata[EVT_W-1:0]) | evt_in;
      end else begin
         evt_status_reg <= evt_status_reg | evt_in;
      end
   end

   // event mask
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         evt_mask_reg <= RST_EVT;
      end else if (wr_mask) begin
         evt_mask_reg <= reg_wdata[EVT_W-1:0];
      end
   end

   // assembled status word, combined bits derived on read
   always_comb begin
      status_word = RST_STATUS;
      status_word[BIT_ACC_A_OVERFLOW] = acc_ovf_reg[0];
      status_word[BIT_ACC_B_OVERFLOW] = acc_ovf_reg[1];
      status_word[BIT_ACC_A_SAT] = acc_sat_reg[0];
      status_word[BIT_ACC_B_SAT] = acc_sat_reg[1];
      status_word[BIT_ANY_OVERFLOW] = |acc_ovf_reg;
      status_word[BIT_ANY_SAT] = |acc_sat_reg;
      status_word[BIT_LOOP_ACTIVE] = loop_active_flag;
      status_word[BIT_HALF_CARRY] = half_carry_flag;
      status_word[BIT_PRIO_HI:BIT_PRIO_LO] = cpu_priority_low;
      status_word[BIT_REPEAT_ACTIVE] = repeat_active_flag;
      status_word[BIT_NEGATIVE] = negative_flag;
      status_word[BIT_SIGNED_OVF] = signed_overflow_flag;
      status_word[BIT_ZERO] = zero_flag;
      status_word[BIT_CARRY] = carry_flag;
   end

   // read multiplexer, unmapped offsets read zero
   always_comb begin
      read_mux = '0;
      unique case (reg_addr)
         OFS_STATUS: begin
            read_mux = status_word;
         end
         OFS_CORE_CTRL: begin
            read_mux[BIT_PRIO_TOP] = cpu_priority_top;
         end
         OFS_INT_CTRL_ONE: begin
            read_mux[BIT_NEST_DISABLE] = nesting_disable;
         end
         OFS_EVT_STATUS: begin
            read_mux[EVT_W-1:0] = evt_status_reg;
         end
         OFS_EVT_MASK: begin
            read_mux[EVT_W-1:0] = evt_mask_reg;
         end
         default: begin
            read_mux = '0;
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= read_mux;
      end else begin
         reg_rdata <= '0;
      end
   end

   // registered copies of status and priority for the core
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cpu_status_flags <= RST_STATUS;
         cpu_priority_level <= 4'h0;
         user_irq_block <= 1'b0;
      end else begin
         cpu_status_flags <= status_word;
         cpu_priority_level <= {cpu_priority_top, cpu_priority_low};
         user_irq_block <= cpu_priority_top;
      end
   end

   // level interrupt while any unmasked event is pending
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evt_status_reg & evt_mask_reg);
      end
   end

endmodule

`default_nettype wire

// [cpu_status_checker_assertions.sv]
/*
 * concurrent checks on the ports of the cpu status flag register.
 * assumes one clock domain and the two-edge registered path from flag
 * inputs to the mirrored status word.
 */
`default_nettype none
module cpu_status_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_rd,
   input wire logic [cpu_status_pkg::DATA_W-1:0] reg_rdata,
   input wire logic acc_update,
   input wire logic acc_a_overflow_in,
   input wire logic acc_a_saturate,
   input wire logic acc_b_saturate,
   input wire logic do_loop_busy,
   input wire logic repeat_loop_busy,
   input wire logic alu_update,
   input wire logic alu_byte_op,
   input wire logic [16:0] alu_carries,
   input wire logic [cpu_status_pkg::DATA_W-1:0] cpu_status_flags,
   input wire logic [3:0] cpu_priority_level,
   input wire logic user_irq_block
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // accumulator flags
   property p_ovf_a; acc_update |-> ##2 cpu_status_flags[15] == $past(acc_a_overflow_in, 2); endproperty
   a_ovf_a: assert property (p_ovf_a) else $error("overflow a flag wrong");
   property p_sat_a; acc_a_saturate |-> ##2 cpu_status_flags[13]; endproperty
   a_sat_a: assert property (p_sat_a) else $error("sticky a not set");
   property p_sat_b; acc_b_saturate |-> ##2 cpu_status_flags[12]; endproperty
   a_sat_b: assert property (p_sat_b) else $error("sticky b not set");
   property p_any_ovf; cpu_status_flags[11] == (cpu_status_flags[15] | cpu_status_flags[14]); endproperty
   a_any_ovf: assert property (p_any_ovf) else $error("combined overflow wrong");
   property p_any_sat; cpu_status_flags[10] == (cpu_status_flags[13] | cpu_status_flags[12]); endproperty
   a_any_sat: assert property (p_any_sat) else $error("combined saturation wrong");
   // loop mirrors, alu carry, user block and idle read data
   property p_do_loop; cpu_status_flags[9] == $past(do_loop_busy, 2); endproperty
   a_do_loop: assert property (p_do_loop) else $error("do loop flag wrong");
   property p_repeat; cpu_status_flags[4] == $past(repeat_loop_busy, 2); endproperty
   a_repeat: assert property (p_repeat) else $error("repeat flag wrong");
   property p_carry; alu_update && !alu_byte_op |-> ##2 cpu_status_flags[0] == $past(alu_carries[16], 2); endproperty
   a_carry: assert property (p_carry) else $error("carry flag wrong");
   property p_block; user_irq_block == cpu_priority_level[3]; endproperty
   a_block: assert property (p_block) else $error("user block wrong");
   property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   c_sat: cover property (acc_a_saturate);
   c_loop: cover property (do_loop_busy && repeat_loop_busy);
   c_block: cover property ($rose(user_irq_block));
endmodule
bind cpu_status_flag_register cpu_status_checker chk (.clk, .rst_n, .reg_rd, .reg_rdata, .acc_update,
   .acc_a_overflow_in, .acc_a_saturate, .acc_b_saturate, .do_loop_busy, .repeat_loop_busy, .alu_update,
   .alu_byte_op, .alu_carries, .cpu_status_flags, .cpu_priority_level, .user_irq_block);
`default_nettype wire

// [tb_cpu_status_flag_register.sv]
/*
 * directed testbench for the cpu status flag register.
 * assumes the register port returns read data in the cycle after the strobe.
 */
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb_cpu_status_flag_register import cpu_status_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, acc_update = 0, oa = 0, ob = 0, sa = 0, sb = 0;
   logic do_busy = 0, rep_busy = 0, alu_update = 0, bop = 0, prio_load = 0, neg = 0, zr = 0, zs = 0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, flags, v;
   logic [16:0] cy = '0;
   logic [3:0] prio_val = '0, level;
   logic blk, irq;
   int n_fail = 0;
   int tests_run = 0;
   logic [16:0] cy_t [5] = '{17'h00010, 17'h00100, 17'h10000, 17'h18000, 17'h00100};
   logic bop_t [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   logic [15:0] ex_t [5] = '{16'h0100, 16'h0100, 16'h0005, 16'h0001, 16'h0005};
   cpu_status_flag_register dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_update(acc_update),
      .acc_a_overflow_in(oa), .acc_b_overflow_in(ob), .acc_a_saturate(sa), .acc_b_saturate(sb),
      .do_loop_busy(do_busy), .repeat_loop_busy(rep_busy), .alu_update(alu_update), .alu_byte_op(bop),
      .alu_carries(cy), .alu_negative(neg), .alu_zero(zr), .alu_zero_sticky(zs), .prio_load(prio_load),
      .prio_load_value(prio_val), .cpu_status_flags(flags), .cpu_priority_level(level),
      .user_irq_block(blk), .irq(irq));
   // free running clock
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk); reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the taken edge
   task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk); reg_rd <= 1'b0;
      #1 v = reg_rdata;
      `CHK(v & m, e)
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic acc(input logic a, input logic b);
      @(posedge clk); acc_update <= 1'b1; oa <= a; ob <= b;
      @(posedge clk); acc_update <= 1'b0;
   endtask
   task automatic sat(input logic a, input logic b);
      @(posedge clk); sa <= a; sb <= b;
      @(posedge clk); sa <= 1'b0; sb <= 1'b0;
   endtask
   task automatic alu(input logic b, input logic [16:0] c);
      @(posedge clk); alu_update <= 1'b1; bop <= b; cy <= c;
      @(posedge clk); alu_update <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // watchdog against a hung run
   initial begin
      #500000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      idle(3);
      `CHK(flags, 16'h0000)
      chk_rd(OFS_STATUS, 16'hffff, 16'h0000);
      chk_rd(3'h5, 16'hffff, 16'h0000);
      $display("test reset done");
      acc(1'b1, 1'b0);
      chk_rd(OFS_STATUS, 16'hc800, 16'h8800);
      acc(1'b0, 1'b1);
      chk_rd(OFS_STATUS, 16'hc800, 16'h4800);
      acc(1'b0, 1'b0);
      chk_rd(OFS_STATUS, 16'hc800, 16'h0000);
      $display("test overflow done");
      wr(OFS_EVT_MASK, 16'h0001);
      sat(1'b1, 1'b0);
      idle(3);
      `CHK(irq, 1'b1)
      chk_rd(OFS_STATUS, 16'h3400, 16'h2400);
      chk_rd(OFS_EVT_STATUS, 16'h000f, 16'h000d);
      wr(OFS_EVT_STATUS, 16'h0001);
      sat(1'b0, 1'b1);
      idle(3);
      `CHK(irq, 1'b0)
      chk_rd(OFS_STATUS, 16'h3400, 16'h3400);
      wr(OFS_STATUS, 16'h1400);
      chk_rd(OFS_STATUS, 16'h3400, 16'h1400);
      wr(OFS_STATUS, 16'h3000);
      chk_rd(OFS_STATUS, 16'h3400, 16'h0000);
      wr(OFS_EVT_MASK, 16'h0000);
      $display("test saturation done");
      @(posedge clk); do_busy <= 1'b1; rep_busy <= 1'b1;
      wr(OFS_STATUS, 16'h0000);
      idle(3);
      `CHK(flags & 16'h0210, 16'h0210)
      @(posedge clk); do_busy <= 1'b0; rep_busy <= 1'b0;
      wr(OFS_STATUS, 16'h0210);
      chk_rd(OFS_STATUS, 16'h0210, 16'h0000);
      $display("test loops done");
      for (int i = 0; i < 5; i++) begin
         alu(bop_t[i], cy_t[i]);
         chk_rd(OFS_STATUS, 16'h0105, ex_t[i]);
      end
      // negative and zero, then sticky zero that only clears
      @(posedge clk); neg <= 1'b1; zr <= 1'b1;
      alu(1'b0, 17'h00000);
      chk_rd(OFS_STATUS, 16'h000a, 16'h000a);
      @(posedge clk); neg <= 1'b0; zr <= 1'b0; zs <= 1'b1;
      alu(1'b0, 17'h00000);
      chk_rd(OFS_STATUS, 16'h000a, 16'h0000);
      @(posedge clk); zr <= 1'b1;
      alu(1'b0, 17'h00000);
      chk_rd(OFS_STATUS, 16'h0002, 16'h0000);
      @(posedge clk); zr <= 1'b0; zs <= 1'b0;
      $display("test alu done");
      wr(OFS_STATUS, 16'h00a0);
      idle(3);
      `CHK(level, 4'h5)
      `CHK(blk, 1'b0)
      wr(OFS_CORE_CTRL, 16'h0008);
      idle(3);
      `CHK(level, 4'hd)
      `CHK(blk, 1'b1)
      wr(OFS_INT_CTRL_ONE, 16'h8000);
      wr(OFS_STATUS, 16'h0060);
      chk_rd(OFS_STATUS, 16'h00e0, 16'h00a0);
      @(posedge clk); prio_load <= 1'b1; prio_val <= 4'h2;
      @(posedge clk); prio_load <= 1'b0;
      idle(3);
      `CHK(level, 4'h2)
      `CHK(blk, 1'b0)
      $display("test priority done");
      report_and_stop();
   end
endmodule
`default_nettype wire
